/* File: cml_regs.vh */
// Offsets, field positions and reset values of the payload and length buffer.
// How it works
// - Every buffer holds eight byte-wide payload registers, sent or received.
// - The length code, not the register count, decides how many bytes move.
// - Length register low four bits hold a plain binary length code, 0 to 15.
// - A remote frame sends its length code as written but no payload bytes.
// - Data frame byte count is 0 to 8; length codes 9 to 15 also move eight bytes.
// - Frame-type bit: zero data, one remote; receive reports the received type.
`ifndef CML_REGS_VH
`define CML_REGS_VH
`define CML_ADDR_W        4
`define CML_OFS_PAYLOAD0  4'h0
`define CML_OFS_LENGTH    4'h8
`define CML_OFS_FTYPE     4'h9
`define CML_OFS_STATUS    4'hA
`define CML_OFS_CONTROL   4'hB
`define CML_LEN_LSB       0
`define CML_LEN_MSB       3
`define CML_FTYPE_BIT     4
`define CML_MAX_BYTES     4'h8
`define CML_RST_BYTE      8'h00
`define CML_RST_LEN       4'h0
`endif

/* File: cml_byte_count.v */
// Converts a length code and frame type into the count of payload bytes.
`timescale 1ns/10ps
`default_nettype none
`include "cml_regs.vh"
module cml_byte_count (
  // Frame description
  input  wire [3:0] length_code,
  input  wire       remote,
  // Resulting payload byte count
  output reg  [3:0] count
);
  always @* begin
    if (remote) begin
      count = 4'h0;
    end else if (length_code > `CML_MAX_BYTES) begin
      count = `CML_MAX_BYTES;
    end else begin
      count = length_code;
    end
  end
endmodule
`default_nettype wire

/* File: cml_buffer.v */
// Message buffer payload and length store with transmit and receive streams.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "cml_regs.vh"
module cml_buffer (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       reset,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Transmit byte stream toward the frame engine
  input  wire       tx_start,
  output reg        tx_busy,
  output reg  [3:0] tx_length_code,
  output reg        tx_remote,
  output reg  [7:0] tx_byte,
  output reg        tx_byte_valid,
  input  wire       tx_byte_ready,
  output reg        tx_done,
  // Receive byte stream from the frame engine
  input  wire       rx_start,
  input  wire [3:0] rx_length_code,
  input  wire       rx_remote,
  input  wire [7:0] rx_byte,
  input  wire       rx_byte_valid,
  output reg        rx_done
);
  //////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'b001;
  localparam ST_SEND = 3'b010;
  localparam ST_RECV = 3'b100;

  reg [7:0] payload [0:7];
  reg [3:0] length_code;
  reg       remote;
  reg [2:0] state;
  reg [3:0] index;
  reg [3:0] target;
  reg       rx_seen;
  wire [3:0] buf_count;
  wire [3:0] rx_count;
  integer    i;

  // The buffer's own length code governs transmit count.
  cml_byte_count u_txcnt (
    .length_code (length_code),
    .remote      (remote),
    .count       (buf_count)
  );
  cml_byte_count u_rxcnt (
    .length_code (rx_length_code),
    .remote      (rx_remote),
    .count       (rx_count)
  );

  //////////////////////////////////////////////////////////////////////////
  // Software writes are refused while a frame owns the buffer, so a half
  // sent payload can never be changed under the frame engine.
  wire sw_ok = (state == ST_IDLE);

  always @(posedge clk_sys) begin
    if (reset) begin
      for (i = 0; i < 8; i = i + 1) begin
        payload[i] <= `CML_RST_BYTE;
      end
      length_code   <= `CML_RST_LEN;
      remote        <= 1'b0;
      state         <= ST_IDLE;
      index         <= 4'h0;
      target        <= 4'h0;
      rx_seen       <= 1'b0;
      tx_busy       <= 1'b0;
      tx_length_code <= 4'h0;
      tx_remote     <= 1'b0;
      tx_byte       <= 8'h00;
      tx_byte_valid <= 1'b0;
      tx_done       <= 1'b0;
      rx_done       <= 1'b0;
      reg_rdata     <= 8'h00;
    end else begin
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      if (reg_wr && sw_ok) begin
        if (reg_addr < `CML_OFS_LENGTH) begin
          payload[reg_addr[2:0]] <= reg_wdata;
        end else if (reg_addr == `CML_OFS_LENGTH) begin
          length_code <= reg_wdata[`CML_LEN_MSB:`CML_LEN_LSB];
          remote      <= reg_wdata[`CML_FTYPE_BIT];
        end else if (reg_addr == `CML_OFS_FTYPE) begin
          remote <= reg_wdata[0];
        end
      end
      if (reg_rd) begin
        if (reg_addr < `CML_OFS_LENGTH) begin
          reg_rdata <= payload[reg_addr[2:0]];
        end else if (reg_addr == `CML_OFS_LENGTH) begin
          reg_rdata <= {3'b000, remote, length_code};
        end else if (reg_addr == `CML_OFS_FTYPE) begin
          reg_rdata <= {7'h00, remote};
        end else if (reg_addr == `CML_OFS_STATUS) begin
          reg_rdata <= {3'b000, buf_count, rx_seen};
        end else begin
          reg_rdata <= 8'h00;
        end
      end else begin
        reg_rdata <= 8'h00;
      end
      case (state)
        ST_IDLE: begin
          index <= 4'h0;
          if (tx_start) begin
            state          <= ST_SEND;
            tx_busy        <= 1'b1;
            tx_length_code <= length_code;
            tx_remote      <= remote;
            target         <= buf_count;
            tx_byte        <= payload[0];
            tx_byte_valid  <= (buf_count != 4'h0);
            if (buf_count == 4'h0) begin
              state   <= ST_IDLE;
              tx_busy <= 1'b0;
              tx_done <= 1'b1;
            end
          end else if (rx_start) begin
            state       <= ST_RECV;
            length_code <= rx_length_code;
            remote      <= rx_remote;
            target      <= rx_count;
            rx_seen     <= 1'b0;
            if (rx_count == 4'h0) begin
              state   <= ST_IDLE;
              rx_seen <= 1'b1;
              rx_done <= 1'b1;
            end
          end
        end
        ST_SEND: begin
          if (tx_byte_valid && tx_byte_ready) begin
            if (index + 4'h1 >= target) begin
              tx_byte_valid <= 1'b0;
              tx_busy       <= 1'b0;
              tx_done       <= 1'b1;
              state         <= ST_IDLE;
            end else begin
              index   <= index + 4'h1;
              tx_byte <= payload[index[2:0] + 3'h1];
            end
          end
        end
        ST_RECV: begin
          if (rx_byte_valid) begin
            payload[index[2:0]] <= rx_byte;
            if (index + 4'h1 >= target) begin
              state   <= ST_IDLE;
              rx_seen <= 1'b1;
              rx_done <= 1'b1;
            end else begin
              index <= index + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: cml_monitor.sv */
// Checker for the transmit side of the payload and length buffer.
`timescale 1ns/10ps
`default_nettype none
module cml_monitor (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       tx_busy,
  input wire logic [3:0] tx_length_code,
  input wire logic       tx_remote,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_byte_valid,
  input wire logic       tx_byte_ready,
  input wire logic       tx_done
);
  logic [4:0] n;
  wire  [4:0] exp_n = tx_remote ? 5'h00 :
                      (tx_length_code > 4'h8 ? 5'h08 : {1'b0, tx_length_code});
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Counts accepted bytes so a frame can be judged when it ends.
  always @(posedge clk_sys) begin
    if (reset || tx_done) n <= 5'h00;
    else if (tx_byte_valid && tx_byte_ready) n <= n + 5'h01;
  end
  property p_cnt; tx_done |-> n == exp_n; endproperty
  a_cnt: assert property (p_cnt) else $error("byte count");
  property p_rem; tx_byte_valid |-> !tx_remote; endproperty
  a_rem: assert property (p_rem) else $error("remote data");
  property p_max; n <= 5'h08; endproperty
  a_max: assert property (p_max) else $error("too many bytes");
  property p_hold; tx_byte_valid && !tx_byte_ready |=>
    tx_byte_valid && $stable(tx_byte); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_code; tx_busy |=> $stable(tx_length_code); endproperty
  a_code: assert property (p_code) else $error("code moved");
  property p_done; tx_done |-> !tx_byte_valid && !tx_busy; endproperty
  a_done: assert property (p_done) else $error("late byte");
endmodule
bind cml_buffer cml_monitor i_cml_monitor (.clk_sys, .reset, .tx_busy,
  .tx_length_code, .tx_remote, .tx_byte, .tx_byte_valid, .tx_byte_ready,
  .tx_done);
`default_nettype wire

/* File: cml_node.sv */
// Far node model: takes transmit bytes, stalling when told to.
`timescale 1ns/10ps
`default_nettype none
module cml_node (
  input  wire logic       clk_sys,
  input  wire logic       stall,
  input  wire logic       tx_byte_valid,
  input  wire logic [7:0] tx_byte,
  output wire logic       tx_byte_ready
);
  logic [7:0] q[$];
  assign tx_byte_ready = !stall;
  always @(posedge clk_sys) begin
    if (tx_byte_valid && tx_byte_ready) q.push_back(tx_byte);
  end
endmodule
`default_nettype wire

/* File: can_msg_payload_length_test.sv */
// Self-checking bench for the payload and length buffer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module can_msg_payload_length_test;
  logic       clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, stall = 0;
  logic       tx_start = 0, rx_start = 0, rx_remote = 0, rx_byte_valid = 0;
  logic [3:0] reg_addr = 0, rx_length_code = 0;
  logic [7:0] reg_wdata = 0, rx_byte = 0;
  wire        tx_done, rx_done, rdy, tx_busy, tx_remote, tx_byte_valid;
  wire  [3:0] tx_length_code;
  wire  [7:0] reg_rdata, tx_byte;
  logic [31:0] s = 32'h1e9a_996c;
  logic [7:0] m [8];
  int         n_errors = 0, total_checks = 0, t, c, r, k;
  cml_buffer i_cml_buffer (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_start, .tx_busy, .tx_length_code, .tx_remote,
    .tx_byte, .tx_byte_valid, .tx_byte_ready(rdy), .tx_done, .rx_start,
    .rx_length_code, .rx_remote, .rx_byte, .rx_byte_valid, .rx_done);
  cml_node i_cml_node (.clk_sys, .stall, .tx_byte_valid, .tx_byte,
    .tx_byte_ready(rdy));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  initial forever #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) stall <= rnd() > 32'ha000_0000;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys) reg_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys) reg_rd <= 0;
    #1 `CHK(reg_rdata, e)
  endtask
  // Bounded wait, since a missing done pulse must not hang the run.
  task automatic wd;
    for (t = 0; !(tx_done | rx_done) && t < 60; t++) @(posedge clk_sys) #1;
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 0;
    for (k = 0; k < 8; k++) begin
      m[k] = 8'(rnd());
      wr(4'(k), m[k]);
    end
    wr(4'hc, 8'h5a);
    rd(4'hc, 8'h00);
    for (c = 0; c < 32; c++) begin
      r = c / 16;
      k = r ? 0 : (c % 16 > 8 ? 8 : c % 16);
      wr(4'h8, {3'b0, 1'(r), 4'(c)});
      rd(4'h8, {3'b0, 1'(r), 4'(c)});
      i_cml_node.q = {};
      @(posedge clk_sys) tx_start <= 1;
      @(posedge clk_sys) tx_start <= 0;
      #1 wd;
      `CHK(tx_done, 1'b1)
      `CHK(tx_busy, 1'b0)
      `CHK(tx_length_code, 4'(c))
      `CHK(tx_remote, 1'(r))
      `CHK(i_cml_node.q.size(), k)
      for (t = 0; t < k; t++) `CHK(i_cml_node.q[t], m[t])
      @(posedge clk_sys);
      rx_start <= 1;
      rx_length_code <= 4'(c);
      rx_remote <= 1'(r);
      for (t = 0; t < k; t++) begin
        @(posedge clk_sys);
        rx_start <= 0;
        m[t] = 8'(rnd());
        rx_byte <= m[t];
        rx_byte_valid <= 1;
      end
      @(posedge clk_sys);
      rx_start <= 0;
      rx_byte_valid <= 0;
      #1 wd;
      `CHK(rx_done, 1'b1)
      for (t = 0; t < 8; t++) rd(4'(t), m[t]);
      rd(4'h8, {3'b0, 1'(r), 4'(c)});
      rd(4'ha, {3'b0, 4'(k), 1'b1});
    end
    end_sim;
  end
  initial begin
    #1000000;
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
